// ---- common/tcp_pkg.sv ----
// package: register map, field layout and codes of the timer clock block
package tcp_pkg;
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFS_CLK_SEL = 3'h0;
	localparam logic [2:0] OFS_CONTROL = 3'h1;
	localparam logic [2:0] OFS_CONFIG = 3'h2;
	localparam logic [2:0] OFS_COUNT = 3'h3;
	localparam logic [2:0] OFS_PERIOD = 3'h4;
	localparam logic [7:0] RST_CLK_SEL = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hff;
	localparam int CTL_RUN_BIT = 7;
	localparam int CTL_PS_LSB = 4;
	localparam int CTL_POST_LSB = 0;
	localparam int CFG_SYNC_BIT = 0;
	localparam int CFG_ONESHOT_BIT = 1;
	localparam int SRC_NUM = 10;
	// clock select codes
	localparam logic [3:0] CS_FOSC4 = 4'h0;
	localparam logic [3:0] CS_FOSC = 4'h1;
	localparam logic [3:0] CS_HFOSC = 4'h2;
	localparam logic [3:0] CS_LFOSC = 4'h3;
	localparam logic [3:0] CS_ZCD = 4'h4;
	localparam logic [3:0] CS_MFOSC = 4'h5;
	localparam logic [3:0] CS_PIN = 4'h6;
	localparam logic [3:0] CS_LC1 = 4'h7;
	localparam logic [3:0] CS_LC4 = 4'ha;
	localparam logic [3:0] CS_ANGULAR = 4'hb;
	localparam logic [1:0] FOSC4_LAST = 2'h3;
	localparam int OSC_LF = 0;
	localparam int OSC_MF = 1;
	localparam int OSC_HF = 2;
endpackage

// ---- common/tcp_tick_if.sv ----
// interface: tick chain from clock selector through prescaler to the core
`timescale 1ns/10ps
`default_nettype none
interface tcp_tick_if;
	logic raw_tick;
	logic pre_tick;
	logic run;
	logic [3:0] clk_sel;
	logic [2:0] ps_field;
	modport sel (input clk_sel, output raw_tick);
	modport pre (input raw_tick, input run, input ps_field, output pre_tick);
	modport core (input pre_tick, output run, output clk_sel, output ps_field);
endinterface
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking testbench of the timer clock block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import tcp_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic sleep = 1'b0;
	logic [SRC_NUM-1:0] src_in = '0;
	logic period_match;
	logic postscaled;
	logic [2:0] osc_keep;
	int fails = 0;
	int checked = 0;
	int n;
	int k;
	logic [7:0] v;

	// free-running 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	tcp_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sleep(sleep), .src_in(src_in),
		.period_match(period_match), .postscaled(postscaled), .osc_keep(osc_keep));

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cyc(input int got, input int exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t interval %0d expected %0d", $time, got, exp);
		end
	endtask

	// single-cycle strobes, one idle cycle after each write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask

	// bounded wait for the next pulse; returns cycles waited
	task automatic wait_pulse(input bit post, output int cyc);
		cyc = 0;
		do begin
			@(posedge ref_clk);
			#1 cyc++;
			if (cyc > 9000) begin
				fails++;
				summarize();
			end
		end while ((post ? postscaled : period_match) !== 1'b1);
	endtask

	function automatic int exp_cyc(input int code, input int per, input int pre, input int post);
		return (code == 0 ? 4 : 1) * (per + 1) * (1 << pre) * (post + 1);
	endfunction

	task automatic setup(input int code, input int per, input logic [7:0] ctl);
		wr(OFS_COUNT, 8'h00);
		wr(OFS_PERIOD, 8'(per));
		wr(OFS_CLK_SEL, 8'(code));
		wr(OFS_CONTROL, ctl);
	endtask

	// one rising edge per pair of cycles on the chosen bit; other bits random noise
	task automatic pulse(input int cnt, input int idx);
		repeat (cnt) begin
			@(posedge ref_clk);
			src_in <= SRC_NUM'($urandom) | (SRC_NUM'(1) << idx);
			@(posedge ref_clk);
			src_in <= SRC_NUM'($urandom) & ~(SRC_NUM'(1) << idx);
		end
		@(posedge ref_clk);
		src_in <= '0;
		repeat (4) @(posedge ref_clk);
	endtask

	// two full postscaled periods; the first one absorbs start-up latency
	task automatic run_int(input int code, input int per, input int pre, input int post);
		setup(code, per, {1'b1, 3'(pre), 4'(post)});
		wait_pulse(1'b1, n);
		wait_pulse(1'b1, n);
		chk_cyc(n, exp_cyc(code, per, pre, post));
		wr(OFS_CONTROL, 8'h00);
	endtask

	initial begin
		k = $urandom(32'h436f214d);
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		// reset values, unmapped places read zero
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), v);
			chk_reg(v, (a == 4) ? 8'hff : 8'h00);
		end
		wr(OFS_CLK_SEL, 8'hff);
		rd(OFS_CLK_SEL, v);
		chk_reg(v, 8'h0f);
		wr(3'h6, 8'h5a);
		rd(3'h6, v);
		chk_reg(v, 8'h00);
		k = $urandom & 32'h7f;
		wr(OFS_CONTROL, 8'(k));
		rd(OFS_CONTROL, v);
		chk_reg(v, 8'(k));
		wr(OFS_CONTROL, 8'h00);
		// every prescale step, each on a random one of the two system clock codes
		for (int p = 0; p < 8; p++) begin
			run_int($urandom % 2, 1 + $urandom % 7, p, 0);
		end
		// postscale corners 1:16 and period zero, then random
		for (int t = 0; t < 6; t++) begin
			run_int($urandom % 2, (t == 1) ? 0 : 1 + $urandom % 15, $urandom % 2,
				(t == 0) ? 15 : $urandom % 16);
		end
		// each selectable source counts only its own edges, angular clock included
		for (int c = 2; c < 12; c++) begin
			k = 1 + $urandom % 8;
			setup(c, 8'hff, 8'h80);
			pulse(k, c - 2);
			rd(OFS_COUNT, v);
			chk_reg(v, 8'(k));
		end
		// reserved codes give no ticks
		for (int c = 12; c < 16; c++) begin
			setup(c, 8'hff, 8'h80);
			pulse(4, c % SRC_NUM);
			rd(OFS_COUNT, v);
			chk_reg(v, 8'h00);
		end
		// asleep with sync set: frozen count, refused writes
		wr(OFS_CONFIG, 8'h01);
		setup(CS_HFOSC, 8'hff, 8'h80);
		sleep <= 1'b1;
		pulse(5, 0);
		wr(OFS_COUNT, 8'h33);
		wr(OFS_PERIOD, 8'h12);
		rd(OFS_COUNT, v);
		chk_reg(v, 8'h00);
		rd(OFS_PERIOD, v);
		chk_reg(v, 8'hff);
		chk_reg({5'h00, osc_keep}, 8'h04);
		wr(OFS_CLK_SEL, 8'(CS_LFOSC));
		repeat (2) @(posedge ref_clk);
		#1 chk_reg({5'h00, osc_keep}, 8'h01);
		wr(OFS_CLK_SEL, 8'(CS_MFOSC));
		repeat (2) @(posedge ref_clk);
		#1 chk_reg({5'h00, osc_keep}, 8'h02);
		// sync clear: still counts in sleep
		wr(OFS_CONFIG, 8'h00);
		wr(OFS_CLK_SEL, 8'(CS_HFOSC));
		pulse(5, 0);
		rd(OFS_COUNT, v);
		chk_reg(v, 8'h05);
		sleep <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1 chk_reg({5'h00, osc_keep}, 8'h00);
		// one-shot: hardware drops run at the match
		wr(OFS_CONFIG, 8'h02);
		setup(CS_FOSC, 8'h05, 8'h80);
		wait_pulse(1'b0, n);
		repeat (2) @(posedge ref_clk);
		rd(OFS_CONTROL, v);
		chk_reg(v, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire

// ---- src/tcp_clk_sel.sv ----
// clock source selector: turns the chosen source into one-cycle ticks
`timescale 1ns/10ps
`default_nettype none
module tcp_clk_sel (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [tcp_pkg::SRC_NUM-1:0] src_in,
	tcp_tick_if.sel tk
);
	import tcp_pkg::*;

	logic [SRC_NUM-1:0] src_prev_q;
	logic [1:0] div_q;
	logic tick_q;
	logic sel_d;

	// source levels of the last cycle, for rising-edge detection
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			src_prev_q <= '0;
			div_q <= 2'h0;
		end else begin
			src_prev_q <= src_in;
			div_q <= div_q + 2'h1;
		end
	end

	// code to source; reserved codes give no tick
	always_comb begin
		sel_d = 1'b0;
		if (tk.clk_sel == CS_FOSC4) begin
			sel_d = (div_q == FOSC4_LAST);
		end else if (tk.clk_sel == CS_FOSC) begin
			sel_d = 1'b1;
		end else if (tk.clk_sel <= CS_ANGULAR) begin
			sel_d = src_in[tk.clk_sel - CS_HFOSC] & ~src_prev_q[tk.clk_sel - CS_HFOSC];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= sel_d;
		end
	end
	assign tk.raw_tick = tick_q;

	a_fosc_every: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tk.clk_sel == CS_FOSC |=> tick_q) else $error("system clock source missed a tick");
	a_fosc4_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tk.clk_sel == CS_FOSC4 && div_q != FOSC4_LAST
		|=> !tick_q) else $error("divided clock ticked early");
	a_reserved_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tk.clk_sel > CS_ANGULAR |=> !tick_q) else $error("reserved source ticked");
endmodule
`default_nettype wire

// ---- src/tcp_scaler.sv ----
// prescaler: divides source ticks by a power of two
`timescale 1ns/10ps
`default_nettype none
module tcp_scaler #(
	parameter int CNT_W = 7
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	tcp_tick_if.pre tk
);
	import tcp_pkg::*;

	logic [CNT_W-1:0] pcnt_q;
	logic [CNT_W-1:0] last_w;
	logic tick_q;

	// terminal count is 2^field - 1
	assign last_w = CNT_W'((1 << tk.ps_field) - 1);

	// counter held cleared while stopped so a restart begins a full period
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pcnt_q <= '0;
			tick_q <= 1'b0;
		end else if (!tk.run) begin
			pcnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tk.raw_tick) begin
			pcnt_q <= (pcnt_q >= last_w) ? '0 : pcnt_q + 1'b1;
			tick_q <= (pcnt_q >= last_w);
		end else begin
			tick_q <= 1'b0;
		end
	end
	assign tk.pre_tick = tick_q;

	a_pre_ratio: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tk.run && tk.raw_tick && pcnt_q < last_w |=> !tick_q) else $error("prescaler fired early");
	a_pre_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!tk.run |=> pcnt_q == '0 && !tick_q) else $error("prescaler not cleared");
endmodule
`default_nettype wire

// ---- src/tcp_timer.sv ----
// timer core: registers, period counter, postscaler and sleep handling
// Functional notes
// - sync set: no counting during sleep
// - sync set sleep: count and period frozen
// - sync clear: counts in sleep while clocked
// - chosen internal oscillator kept running in sleep
// - codes 0..5 pick system clocks, oscillators, zero-cross
// - 6 pin, 7..a logic cells, b angular
// - clock select upper nibble reads zero
// - prescale divides by two to the field
// - postscale divides matches by field plus one
// - run bit cleared by hardware in one-shot
// - count equal period clears on next tick
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tcp_timer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [tcp_pkg::ADDR_W-1:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic sleep,
	input wire logic [tcp_pkg::SRC_NUM-1:0] src_in,
	output logic period_match,
	output logic postscaled,
	output logic [2:0] osc_keep
);
	import tcp_pkg::*;

	tcp_tick_if tk ();

	logic [3:0] clk_sel_q;
	logic run_q;
	logic [2:0] ps_q;
	logic [3:0] post_q;
	logic sync_q;
	logic oneshot_q;
	logic [7:0] count_q;
	logic [7:0] period_q;
	logic [3:0] post_cnt_q;
	logic [7:0] rd_data_q;
	logic match_q;
	logic post_out_q;
	logic [2:0] osc_keep_q;
	logic frozen_w;
	logic step_w;
	logic hit_w;
	logic wr_ctl_w;

	tcp_clk_sel u_sel (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.src_in(src_in),
		.tk(tk)
	);

	tcp_scaler u_pre (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.tk(tk)
	);

	assign tk.run = run_q;
	assign tk.clk_sel = clk_sel_q;
	assign tk.ps_field = ps_q;

	// a synchronised timer depends on the core clock, which stops in sleep
	assign frozen_w = sync_q && sleep;
	assign step_w = tk.pre_tick && run_q && !frozen_w;
	assign hit_w = step_w && (count_q == period_q);
	assign wr_ctl_w = wr_en && addr == OFS_CONTROL;

	// clock select and configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			clk_sel_q <= RST_CLK_SEL[3:0];
			sync_q <= RST_CONFIG[CFG_SYNC_BIT];
			oneshot_q <= RST_CONFIG[CFG_ONESHOT_BIT];
		end else if (wr_en && addr == OFS_CLK_SEL) begin
			clk_sel_q <= wr_data[3:0];
		end else if (wr_en && addr == OFS_CONFIG) begin
			sync_q <= wr_data[CFG_SYNC_BIT];
			oneshot_q <= wr_data[CFG_ONESHOT_BIT];
		end
	end

	// control register; a software write of run wins over the hardware clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			run_q <= RST_CONTROL[CTL_RUN_BIT];
			ps_q <= RST_CONTROL[CTL_PS_LSB +: 3];
			post_q <= RST_CONTROL[CTL_POST_LSB +: 4];
		end else if (wr_ctl_w) begin
			run_q <= wr_data[CTL_RUN_BIT];
			ps_q <= wr_data[CTL_PS_LSB +: 3];
			post_q <= wr_data[CTL_POST_LSB +: 4];
		end else if (oneshot_q && hit_w) begin
			run_q <= 1'b0;
		end
	end

	// period register; writes ignored while frozen in sleep
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			period_q <= RST_PERIOD;
		end else if (wr_en && addr == OFS_PERIOD && !frozen_w) begin
			period_q <= wr_data;
		end
	end

	// count register: wraps to zero on the same tick as a period match, when the tick finds count equal to period
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_q <= RST_COUNT;
		end else if (wr_en && addr == OFS_COUNT && !frozen_w) begin
			count_q <= wr_data;
		end else if (hit_w) begin
			count_q <= 8'h00;
		end else if (step_w) begin
			count_q <= count_q + 8'h01;
		end
	end

	// postscaler counts period matches; cleared while stopped
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			post_cnt_q <= 4'h0;
			post_out_q <= 1'b0;
			match_q <= 1'b0;
		end else if (!run_q) begin
			post_cnt_q <= 4'h0;
			post_out_q <= 1'b0;
			match_q <= 1'b0;
		end else begin
			match_q <= hit_w;
			post_out_q <= hit_w && (post_cnt_q >= post_q);
			if (hit_w) begin
				post_cnt_q <= (post_cnt_q >= post_q) ? 4'h0 : post_cnt_q + 4'h1;
			end
		end
	end

	// oscillator keep-alive requests during sleep
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			osc_keep_q <= 3'h0;
		end else begin
			osc_keep_q[OSC_LF] <= sleep && clk_sel_q == CS_LFOSC;
			osc_keep_q[OSC_MF] <= sleep && clk_sel_q == CS_MFOSC;
			osc_keep_q[OSC_HF] <= sleep && clk_sel_q == CS_HFOSC;
		end
	end

	// read port: data stand the cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_data_q <= 8'h00;
		end else if (!rd_en) begin
			rd_data_q <= 8'h00;
		end else if (addr == OFS_CLK_SEL) begin
			rd_data_q <= {4'h0, clk_sel_q};
		end else if (addr == OFS_CONTROL) begin
			rd_data_q <= {run_q, ps_q, post_q};
		end else if (addr == OFS_CONFIG) begin
			rd_data_q <= {6'h00, oneshot_q, sync_q};
		end else if (addr == OFS_COUNT) begin
			rd_data_q <= count_q;
		end else if (addr == OFS_PERIOD) begin
			rd_data_q <= period_q;
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	assign rd_data = rd_data_q;
	assign period_match = match_q;
	assign postscaled = post_out_q;
	assign osc_keep = osc_keep_q;

	// helper state for the checks: frozen-sleep snapshot and match tally
	logic [7:0] frz_len_q;
	logic [7:0] frz_count_q;
	logic [7:0] frz_period_q;
	logic [4:0] mseen_q;
	logic mok_q;

	// snapshot at the first frozen cycle, so a sleep of any length is checked
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			frz_len_q <= 8'h00;
			frz_count_q <= RST_COUNT;
			frz_period_q <= RST_PERIOD;
		end else if (!frozen_w) begin
			frz_len_q <= 8'h00;
		end else begin
			if (frz_len_q == 8'h00) begin
				frz_count_q <= count_q;
				frz_period_q <= period_q;
			end
			if (frz_len_q != 8'hff) begin
				frz_len_q <= frz_len_q + 8'h01;
			end
		end
	end

	// matches since the last postscaled pulse; a reprogram mid-run voids the tally
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mseen_q <= 5'h00;
			mok_q <= 1'b1;
		end else if (!run_q) begin
			mseen_q <= 5'h00;
			mok_q <= 1'b1;
		end else begin
			if (match_q) begin
				mseen_q <= post_out_q ? 5'h00 : mseen_q + 5'h01;
			end
			if (wr_ctl_w) begin
				mok_q <= 1'b0;
			end
		end
	end

	// sleep handling and oscillator keep-alive
	a_sleep_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sync_q && sleep
		|=> count_q == $past(count_q)) else $error("count moved in sleep");
	a_period_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sync_q && sleep
		|=> $stable(period_q)) else $error("period moved in sleep");
	a_frozen_snap: assert property (@(posedge ref_clk) disable iff (!rst_n)
		frz_len_q != 8'h00
		|-> count_q == frz_count_q && period_q == frz_period_q) else $error("frozen value drifted");
	a_frozen_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		frozen_w && wr_en && addr == OFS_COUNT
		|=> count_q == $past(count_q)) else $error("count written in sleep");
	a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!sync_q && run_q && tk.pre_tick && count_q != period_q && !wr_en
		|=> count_q == $past(count_q) + 8'h01) else $error("count failed to step");
	a_wake_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!sync_q && sleep && step_w && !hit_w && !wr_en
		|=> count_q == $past(count_q) + 8'h01) else $error("count stopped in sleep");
	a_osc_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sleep && clk_sel_q == CS_LFOSC
		|=> osc_keep_q[OSC_LF]) else $error("osc not kept");
	a_osc_mf: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sleep && clk_sel_q == CS_MFOSC
		|=> osc_keep_q[OSC_MF]) else $error("medium osc not kept");
	a_osc_hf: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sleep && clk_sel_q == CS_HFOSC
		|=> osc_keep_q[OSC_HF]) else $error("high osc not kept");
	a_osc_awake: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!sleep
		|=> osc_keep_q == 3'h0) else $error("osc kept while awake");

	// register writes and read-back
	a_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en && addr == OFS_CLK_SEL
		|=> clk_sel_q == $past(wr_data[3:0])) else $error("clock select not stored");
	a_sel_upper: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_en && addr == OFS_CLK_SEL
		|=> rd_data_q[7:4] == 4'h0) else $error("upper bits set");
	a_rd_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_en && addr == OFS_CLK_SEL
		|=> rd_data_q == {4'h0, $past(clk_sel_q)}) else $error("clock select misread");
	a_period_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en && addr == OFS_PERIOD && !frozen_w
		|=> period_q == $past(wr_data)) else $error("period write lost");
	a_run_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_ctl_w
		|=> run_q == $past(wr_data[CTL_RUN_BIT])) else $error("run write lost");
	a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		oneshot_q && hit_w && !wr_en
		|=> !run_q ##1 !match_q) else $error("run not cleared");
	a_oneshot_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!oneshot_q && hit_w && !wr_en
		|=> run_q) else $error("run dropped in continuous mode");

	// period match, wrap and postscaler
	a_match_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		match_q
		|-> $past(step_w) && $past(count_q) == $past(period_q)) else $error("match without equal");
	a_wrap_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hit_w && !wr_en
		|=> count_q == 8'h00 && match_q) else $error("count did not wrap");
	a_post_ratio: assert property (@(posedge ref_clk) disable iff (!rst_n)
		post_out_q
		|-> match_q) else $error("postscaled without match");
	a_post_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
		run_q && hit_w && post_cnt_q >= post_q
		|=> post_out_q && post_cnt_q == 4'h0) else $error("postscaler did not fire");
	a_post_tally: assert property (@(posedge ref_clk) disable iff (!rst_n)
		post_out_q && mok_q
		|-> mseen_q == {1'b0, post_q}) else $error("postscale ratio wrong");
	a_stop_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!run_q
		|=> post_cnt_q == 4'h0) else $error("postscaler not cleared");
	a_stop_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!run_q && !wr_en
		|=> $stable(count_q)) else $error("count moved while stopped");
endmodule
`default_nettype wire
